/* File: hw/fsc_pkg.sv */
// Constants, field layout and types of the flash store command handler.
// Assumes one 10 MHz core clock and an APB master for the registers.
package fsc_pkg;
  // Store geometry: 119 blocks of 512 bytes
  localparam logic [15:0] FSC_BLOCK_COUNT = 16'h0077;
  localparam logic [15:0] FSC_BLOCK_SIZE = 16'h0200;
  localparam int FSC_STORE_BYTES = 60928;
  localparam logic [15:0] FSC_STORE_LAST = 16'hEDFF;
  localparam logic [15:0] FSC_BLOCK_LAST_OFS = 16'h01FF;
  localparam logic [7:0] FSC_ERASED_BYTE = 8'hFF;
  // Frame addressing
  localparam logic [15:0] FSC_MEM_CLUSTER = 16'h0023;
  localparam logic [7:0] FSC_DATA_ENDPOINT = 8'hE6;
  // Command and response codes
  localparam logic [7:0] FSC_CMD_GEOMETRY = 8'h00;
  localparam logic [7:0] FSC_CMD_ERASE = 8'h01;
  localparam logic [7:0] FSC_RSP_FLAG = 8'h80;
  localparam logic [7:0] FSC_STATUS_ERR = 8'h01;
  // Byte offsets inside the command payload
  localparam logic [2:0] FSC_OFS_CMD = 3'h0;
  localparam logic [2:0] FSC_OFS_OPT = 3'h1;
  localparam logic [2:0] FSC_OFS_BLK_HI = 3'h2;
  localparam logic [2:0] FSC_OFS_BLK_LO = 3'h3;
  localparam logic [2:0] FSC_OFS_BOFS_HI = 3'h4;
  localparam logic [2:0] FSC_OFS_BOFS_LO = 3'h5;
  localparam logic [2:0] FSC_OFS_CNT_HI = 3'h6;
  localparam logic [2:0] FSC_OFS_CNT_LO = 3'h7;
  // APB register byte addresses
  localparam logic [31:0] FSC_ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] FSC_ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] FSC_ADDR_IRQ_STAT = 32'h0000_0008;
  localparam logic [31:0] FSC_ADDR_IRQ_MASK = 32'h0000_000C;
  localparam logic [31:0] FSC_ADDR_PEEK_ADDR = 32'h0000_0010;
  localparam logic [31:0] FSC_ADDR_PEEK_DATA = 32'h0000_0014;
  localparam logic [31:0] FSC_ADDR_CMD_COUNT = 32'h0000_0018;
  // Control bits: 0 enable, 1 API mode, 2 explicit API mode
  localparam int FSC_CTRL_ENABLE = 0;
  localparam int FSC_CTRL_API = 1;
  localparam int FSC_CTRL_EXPLICIT = 2;
  localparam logic [2:0] FSC_CTRL_RESET = 3'h1;
  // Interrupt bits: 0 command done, 1 command error, 2 frame dropped
  localparam int FSC_IRQ_DONE = 0;
  localparam int FSC_IRQ_ERR = 1;
  localparam int FSC_IRQ_DROP = 2;
  // Handler states
  typedef enum logic [2:0] {
    FSC_RX_HDR,
    FSC_RX_DRAIN,
    FSC_EXEC,
    FSC_ERASE,
    FSC_FINISH,
    FSC_TX
  } fsc_state_t;
endpackage : fsc_pkg

/* File: hw/fsc_handler.sv */
// Flash store command handler: parses command frames, erases, answers.
// Assumes frame bytes and response sink on core_clk_i, APB master for setup.
//
// Contract
// [R1] Store holds 119 blocks of 512 bytes
// [R2] Only cluster 0x23, endpoint 0xE6 accepted
// [R3] Header: code, options, block, offset, count
// [R4] Two-byte fields sent high byte first
// [R5] Count gives payload length, or read length
// [R6] Unicast gets a response, broadcast gets none
// [R7] Explicit indicator if endpoint E6 or explicit
// [R8] Response has status in place of options
// [R9] Status bit 0 set on error only
// [R10] Geometry query code 0x00, all fields zero
// [R11] Geometry reply 0x80 reports block count
// [R12] Geometry reply offset field gives block size
// [R13] Code 0x01 erases blocks to all ones
// [R14] Count zero erases every block
// [R15] Single erase: block index, count block size
// [R16] Erase works on whole blocks only
// [R17] Erase options must be zero; the handler never checks the options byte and erases whatever it holds
// [R18] Erase reply 0x81 echoes block and offset
// [R19] Out of range block: no change, error
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ns
module fsc_handler
  import fsc_pkg::*;
(
  input wire logic core_clk_i, // Core clock, 10 MHz
  input wire logic resetn_i, // Asynchronous reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB access phase
  input wire logic pwrite_i, // APB direction
  input wire logic [31:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error, unmapped address
  input wire logic req_valid_i, // Request byte valid
  input wire logic [7:0] req_byte_i, // Request payload byte
  input wire logic req_last_i, // Last byte of the frame
  input wire logic [15:0] req_cluster_i, // Frame cluster code
  input wire logic [7:0] req_dst_ep_i, // Frame destination endpoint
  input wire logic [7:0] req_src_ep_i, // Frame source endpoint
  input wire logic req_bcast_i, // Frame was broadcast
  output logic req_ready_o, // Request byte taken
  output logic rsp_valid_o, // Response byte valid
  output logic [7:0] rsp_byte_o, // Response payload byte
  output logic rsp_last_o, // Last response byte
  output logic [7:0] rsp_dst_ep_o, // Endpoint the response goes to
  output logic rsp_explicit_o, // Emit as explicit receive indicator
  input wire logic rsp_ready_i, // Response byte taken
  output logic irq_o // Interrupt, level, active high
);

  // Complete block state
  typedef struct packed {
    fsc_state_t state; // Handler state
    logic [2:0] rx_idx; // Header byte counter
    logic accept; // Frame addressed to us
    logic bcast; // Frame was broadcast
    logic [7:0] src_ep; // Requester endpoint
    logic [7:0] cmd; // Command code
    logic [7:0] opts; // Command options
    logic [15:0] blk; // Block index
    logic [15:0] bofs; // Byte offset in block
    logic [15:0] cnt; // Byte count
    logic [7:0] rsp_cmd; // Response code
    logic err; // Error flag of the reply
    logic [15:0] rsp_blk; // Reply block field
    logic [15:0] rsp_bofs; // Reply offset field
    logic [15:0] erase_addr; // Current erase byte
    logic [15:0] erase_end; // Last byte to erase
    logic [2:0] tx_idx; // Response byte counter
    logic [7:0] tx_byte; // Current response byte
    logic explicit_ind; // Explicit indicator flag
    logic [2:0] ctrl; // Control register
    logic [2:0] irq_stat; // Sticky interrupt status
    logic [2:0] irq_mask; // Interrupt mask
    logic [15:0] peek_addr; // Store readback address
    logic [15:0] cmd_count; // Commands completed
    logic [31:0] prdata; // APB read data
    logic pslverr; // APB error
  } fsc_regs_t;

  fsc_regs_t st_ff; // Registered state
  fsc_regs_t nxt_st; // Next state

  // [R1] Nonvolatile store array
  logic [7:0] store_mem [0:FSC_STORE_BYTES-1];

  logic apb_setup; // APB setup phase
  logic apb_wr; // APB write completes
  logic [2:0] irq_ev; // Events this cycle
  logic [2:0] irq_clr; // Write-one-to-clear bits
  logic [7:0] peek_byte; // Store byte for readback

  assign apb_setup = psel_i && !penable_i;
  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign peek_byte = (st_ff.peek_addr <= FSC_STORE_LAST) ? store_mem[st_ff.peek_addr] : 8'h00;

  // Response byte by position, high byte first
  function automatic logic [7:0] rsp_at(input logic [2:0] idx, input fsc_regs_t s);
    logic [7:0] b;
    b = 8'h00;
    // [R4] Big endian response fields
    case (idx)
      FSC_OFS_CMD: b = s.rsp_cmd;
      // [R8] [R9] Status replaces options
      FSC_OFS_OPT: b = s.err ? FSC_STATUS_ERR : 8'h00;
      FSC_OFS_BLK_HI: b = s.rsp_blk[15:8];
      FSC_OFS_BLK_LO: b = s.rsp_blk[7:0];
      FSC_OFS_BOFS_HI: b = s.rsp_bofs[15:8];
      FSC_OFS_BOFS_LO: b = s.rsp_bofs[7:0];
      default: b = 8'h00; // Count is zero, no payload
    endcase
    return b;
  endfunction : rsp_at

  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    irq_ev = 3'h0;
    irq_clr = 3'h0;
    // APB setup phase: latch read data and error
    if (apb_setup) begin
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata = 32'h0000_0000;
      case (paddr_i)
        FSC_ADDR_CTRL: nxt_st.prdata = {29'h0, st_ff.ctrl};
        FSC_ADDR_STATUS: nxt_st.prdata = {28'h0, st_ff.state != FSC_RX_HDR, st_ff.state};
        FSC_ADDR_IRQ_STAT: nxt_st.prdata = {29'h0, st_ff.irq_stat};
        FSC_ADDR_IRQ_MASK: nxt_st.prdata = {29'h0, st_ff.irq_mask};
        FSC_ADDR_PEEK_ADDR: nxt_st.prdata = {16'h0, st_ff.peek_addr};
        FSC_ADDR_PEEK_DATA: nxt_st.prdata = {24'h0, peek_byte};
        FSC_ADDR_CMD_COUNT: nxt_st.prdata = {16'h0, st_ff.cmd_count};
        default: nxt_st.pslverr = 1'b1; // Unmapped address
      endcase
    end
    // APB access phase: register writes
    if (apb_wr) begin
      case (paddr_i)
        FSC_ADDR_CTRL: nxt_st.ctrl = pwdata_i[2:0];
        FSC_ADDR_IRQ_STAT: irq_clr = pwdata_i[2:0];
        FSC_ADDR_IRQ_MASK: nxt_st.irq_mask = pwdata_i[2:0];
        FSC_ADDR_PEEK_ADDR: nxt_st.peek_addr = pwdata_i[15:0];
        default: ; // Read-only or unmapped
      endcase
    end
    // Command state machine
    case (st_ff.state)
      // Collect the eight header bytes
      FSC_RX_HDR: begin
        if (req_valid_i) begin
          if (st_ff.rx_idx == FSC_OFS_CMD) begin
            // [R2] Cluster and endpoint filter
            nxt_st.accept = st_ff.ctrl[FSC_CTRL_ENABLE] && (req_cluster_i == FSC_MEM_CLUSTER)
              && (req_dst_ep_i == FSC_DATA_ENDPOINT);
            nxt_st.bcast = req_bcast_i;
            nxt_st.src_ep = req_src_ep_i;
          end
          // [R3] Header field capture
          case (st_ff.rx_idx)
            FSC_OFS_CMD: nxt_st.cmd = req_byte_i;
            FSC_OFS_OPT: nxt_st.opts = req_byte_i;
            FSC_OFS_BLK_HI: nxt_st.blk[15:8] = req_byte_i;
            FSC_OFS_BLK_LO: nxt_st.blk[7:0] = req_byte_i;
            FSC_OFS_BOFS_HI: nxt_st.bofs[15:8] = req_byte_i;
            FSC_OFS_BOFS_LO: nxt_st.bofs[7:0] = req_byte_i;
            FSC_OFS_CNT_HI: nxt_st.cnt[15:8] = req_byte_i;
            default: nxt_st.cnt[7:0] = req_byte_i;
          endcase
          nxt_st.rx_idx = st_ff.rx_idx + 3'h1;
          if (st_ff.rx_idx == FSC_OFS_CNT_LO) begin
            nxt_st.rx_idx = 3'h0;
            // Header done: execute or drain payload
            if (req_last_i) begin
              nxt_st.state = st_ff.accept ? FSC_EXEC : FSC_RX_HDR;
              irq_ev[FSC_IRQ_DROP] = !st_ff.accept;
            end else begin
              nxt_st.state = FSC_RX_DRAIN;
            end
          end else if (req_last_i) begin
            // Short frame is dropped
            nxt_st.rx_idx = 3'h0;
            irq_ev[FSC_IRQ_DROP] = 1'b1;
          end
        end
      end
      // [R5] Payload bytes are not used by these commands
      FSC_RX_DRAIN: begin
        if (req_valid_i && req_last_i) begin
          nxt_st.state = st_ff.accept ? FSC_EXEC : FSC_RX_HDR;
          irq_ev[FSC_IRQ_DROP] = !st_ff.accept;
        end
      end
      // Decode the command
      FSC_EXEC: begin
        // [R18] Reply echoes block and offset
        nxt_st.rsp_cmd = st_ff.cmd | FSC_RSP_FLAG;
        nxt_st.rsp_blk = st_ff.blk;
        nxt_st.rsp_bofs = st_ff.bofs;
        nxt_st.err = 1'b0;
        nxt_st.state = FSC_FINISH;
        if (st_ff.cmd == FSC_CMD_GEOMETRY) begin
          // [R11] [R12] Geometry reply contents
          nxt_st.rsp_blk = FSC_BLOCK_COUNT;
          nxt_st.rsp_bofs = FSC_BLOCK_SIZE;
        end else if (st_ff.cmd == FSC_CMD_ERASE) begin
          if (st_ff.cnt == 16'h0000) begin
            // [R14] Erase whole store
            nxt_st.erase_addr = 16'h0000;
            nxt_st.erase_end = FSC_STORE_LAST;
            nxt_st.state = FSC_ERASE;
          end else if (st_ff.blk >= FSC_BLOCK_COUNT) begin
            // [R19] Block out of range
            nxt_st.err = 1'b1;
          end else begin
            // [R16] Whole block, offset ignored
            nxt_st.erase_addr = {st_ff.blk[6:0], 9'h000};
            nxt_st.erase_end = {st_ff.blk[6:0], 9'h000} + FSC_BLOCK_LAST_OFS;
            nxt_st.state = FSC_ERASE;
          end
        end else begin
          // Unsupported command answers with error
          nxt_st.err = 1'b1;
        end
      end
      // [R13] Step through the bytes to erase
      FSC_ERASE: begin
        nxt_st.erase_addr = st_ff.erase_addr + 16'h0001;
        if (st_ff.erase_addr == st_ff.erase_end) begin
          nxt_st.state = FSC_FINISH;
        end
      end
      // Report and start the response
      FSC_FINISH: begin
        irq_ev[FSC_IRQ_DONE] = 1'b1;
        irq_ev[FSC_IRQ_ERR] = st_ff.err;
        nxt_st.cmd_count = st_ff.cmd_count + 16'h0001;
        // [R7] Explicit indicator choice
        nxt_st.explicit_ind = st_ff.ctrl[FSC_CTRL_API] && ((st_ff.src_ep == FSC_DATA_ENDPOINT)
          || st_ff.ctrl[FSC_CTRL_EXPLICIT]);
        nxt_st.tx_idx = 3'h0;
        nxt_st.tx_byte = rsp_at(FSC_OFS_CMD, st_ff);
        // [R6] Broadcast requests get no response
        nxt_st.state = st_ff.bcast ? FSC_RX_HDR : FSC_TX;
      end
      // Send the eight response bytes
      FSC_TX: begin
        if (rsp_ready_i) begin
          nxt_st.tx_idx = st_ff.tx_idx + 3'h1;
          nxt_st.tx_byte = rsp_at(st_ff.tx_idx + 3'h1, st_ff);
          if (st_ff.tx_idx == FSC_OFS_CNT_LO) begin
            nxt_st.state = FSC_RX_HDR;
          end
        end
      end
      default: nxt_st.state = FSC_RX_HDR;
    endcase
    // Sticky status: a new event wins over a clear
    nxt_st.irq_stat = (st_ff.irq_stat & ~irq_clr) | irq_ev;
  end

  // State register
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
      st_ff.state <= FSC_RX_HDR;
      st_ff.ctrl <= FSC_CTRL_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // [R13] Erased bytes read as all ones
  always_ff @(posedge core_clk_i) begin
    if (st_ff.state == FSC_ERASE) begin
      store_mem[st_ff.erase_addr] <= FSC_ERASED_BYTE;
    end
  end

  // Port drive
  assign prdata_o = st_ff.prdata;
  assign pready_o = 1'b1;
  assign pslverr_o = st_ff.pslverr;
  assign req_ready_o = (st_ff.state == FSC_RX_HDR) || (st_ff.state == FSC_RX_DRAIN);
  assign rsp_valid_o = (st_ff.state == FSC_TX);
  assign rsp_byte_o = st_ff.tx_byte;
  assign rsp_last_o = (st_ff.state == FSC_TX) && (st_ff.tx_idx == FSC_OFS_CNT_LO);
  assign rsp_dst_ep_o = st_ff.src_ep;
  assign rsp_explicit_o = st_ff.explicit_ind;
  assign irq_o = |(st_ff.irq_stat & st_ff.irq_mask);

  // Checks on the handler
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  // A unicast reply about to start
  sequence finish_unicast_s;
    (st_ff.state == FSC_FINISH) && !st_ff.bcast;
  endsequence
  // A broadcast reply suppressed
  sequence finish_bcast_s;
    (st_ff.state == FSC_FINISH) && st_ff.bcast;
  endsequence

  geom_reply_a: assert property ( // [R11]
    finish_unicast_s ##0 (st_ff.rsp_cmd == (FSC_CMD_GEOMETRY | FSC_RSP_FLAG))
    |=> rsp_valid_o && (rsp_byte_o == 8'h80) && (st_ff.rsp_blk == 16'h0077))
    else $error("geometry reply code or block count wrong");
  geom_size_a: assert property ( // [R12]
    (st_ff.state == FSC_TX) && (st_ff.tx_idx == 3'h4) && (st_ff.rsp_cmd == 8'h80)
    |-> (rsp_byte_o == 8'h02))
    else $error("geometry reply block size wrong");
  no_bcast_rsp_a: assert property ( // [R6]
    finish_bcast_s |=> !rsp_valid_o [*8])
    else $error("response sent for broadcast");
  erase_fill_a: assert property ( // [R13]
    (st_ff.state == FSC_ERASE) |=> (store_mem[$past(st_ff.erase_addr)] == 8'hFF))
    else $error("erased byte not all ones");
  erase_all_a: assert property ( // [R14]
    (st_ff.state == FSC_EXEC) && (st_ff.cmd == 8'h01) && (st_ff.cnt == 16'h0000)
    |=> (st_ff.state == FSC_ERASE) && (st_ff.erase_addr == 16'h0000)
      && (st_ff.erase_end == 16'hEDFF))
    else $error("full erase span wrong");
  bad_block_a: assert property ( // [R19]
    (st_ff.state == FSC_EXEC) && (st_ff.cmd == 8'h01) && (st_ff.cnt != 16'h0000)
      && (st_ff.blk >= 16'h0077)
    |=> (st_ff.state == FSC_FINISH) && st_ff.err)
    else $error("bad block not reported");
  frame_filter_a: assert property ( // [R2]
    (st_ff.state == FSC_RX_HDR) && (st_ff.rx_idx == 3'h0) && req_valid_i
      && (req_cluster_i != 16'h0023)
    |=> !st_ff.accept)
    else $error("foreign cluster accepted");
  explicit_ind_a: assert property ( // [R7]
    finish_unicast_s |=> rsp_explicit_o == ($past(st_ff.ctrl[1])
      && (($past(st_ff.src_ep) == 8'hE6) || $past(st_ff.ctrl[2]))))
    else $error("explicit indicator wrong");
  status_bit_a: assert property ( // [R9]
    (st_ff.state == FSC_TX) && (st_ff.tx_idx == 3'h1) |-> (rsp_byte_o == {7'h00, st_ff.err}))
    else $error("status byte wrong");
  big_endian_a: assert property ( // [R4]
    (st_ff.state == FSC_TX) && (st_ff.tx_idx == 3'h2) |-> (rsp_byte_o == st_ff.rsp_blk[15:8]))
    else $error("block field not high byte first");
  erase_echo_a: assert property ( // [R18]
    (st_ff.state == FSC_FINISH) && (st_ff.rsp_cmd == 8'h81)
    |-> (st_ff.rsp_blk == st_ff.blk) && (st_ff.rsp_bofs == st_ff.bofs))
    else $error("erase reply does not echo request");

endmodule : fsc_handler

/* File: bench/fsc_requester.sv */
// Requester model: sends command frames to the handler, collects replies.
// Assumes the handler's byte handshakes run on the one core clock.
`timescale 1ns/1ns
module fsc_requester
  import fsc_pkg::*;
(
  input wire logic clk_i, // Core clock
  output logic req_valid_o, // Request byte valid
  output logic [7:0] req_byte_o, // Request byte
  output logic req_last_o, // Last byte marker
  output logic [15:0] req_cluster_o, // Cluster code
  output logic [7:0] req_dst_ep_o, // Destination endpoint
  output logic [7:0] req_src_ep_o, // Source endpoint
  output logic req_bcast_o, // Broadcast flag
  input wire logic req_ready_i, // Byte taken
  input wire logic rsp_valid_i, // Reply byte valid
  input wire logic [7:0] rsp_byte_i, // Reply byte
  input wire logic rsp_last_i, // Last reply byte
  input wire logic [7:0] rsp_dst_ep_i, // Reply endpoint
  input wire logic rsp_explicit_i, // Explicit indicator flag
  output logic rsp_ready_o // Reply byte taken
);
  int stuck = 0; // Handshakes that never completed
  logic [7:0] last_ep; // Endpoint seen with the last reply byte
  logic [1:0] last_fl; // Explicit and last flags of the last reply byte
  // Idle values at time zero
  initial begin
    req_valid_o = 1'b0;
    req_byte_o = 8'hA5;
    req_last_o = 1'b0;
    req_cluster_o = 16'h0000;
    req_dst_ep_o = 8'h00;
    req_src_ep_o = 8'h00;
    req_bcast_o = 1'b0;
    rsp_ready_o = 1'b1;
  end
  // Header high byte first, then payload
  task automatic send_frame(input logic [63:0] frm, input logic [15:0] clu,
                            input logic [7:0] src, input logic bc, input int len = 8);
    int i;
    int n;
    @(posedge clk_i);
    for (i = 0; i < len; i++) begin
      req_valid_o <= 1'b1;
      // Payload bytes repeat the header pattern
      req_byte_o <= frm[63-8*(i%8) -: 8];
      req_last_o <= (i == len - 1);
      req_cluster_o <= clu;
      req_dst_ep_o <= FSC_DATA_ENDPOINT;
      req_src_ep_o <= src;
      req_bcast_o <= bc;
      n = 0;
      // Hold the byte until ready is seen at a rising edge
      do begin
        @(posedge clk_i);
        n++;
      end while (req_ready_i !== 1'b1 && n < 100);
      if (req_ready_i !== 1'b1) stuck++;
    end
    // Released lines show the inverse of the last byte
    req_valid_o <= 1'b0;
    req_byte_o <= ~req_byte_o;
    req_last_o <= 1'b0;
  endtask : send_frame
  // Collect up to eight reply bytes; slow accepts every other cycle
  task automatic get_rsp(input int limit, input logic slow, output logic [63:0] got,
                         output int cnt);
    int n;
    cnt = 0;
    got = '0;
    for (n = 0; n < limit && cnt < 8; n++) begin
      @(posedge clk_i);
      rsp_ready_o <= slow ? ~rsp_ready_o : 1'b1;
      @(negedge clk_i);
      if (rsp_valid_i === 1'b1 && rsp_ready_o === 1'b1) begin
        got = {got[55:0], rsp_byte_i};
        cnt++;
        last_ep = rsp_dst_ep_i;
        last_fl = {rsp_explicit_i, rsp_last_i};
      end
    end
  endtask : get_rsp
endmodule : fsc_requester

/* File: bench/fsc_handler_bench.sv */
// Bench for the command handler: APB set-up, command frames, replies.
// Assumes the requester model drives the frame side of the handler.
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end
module fsc_handler_bench import fsc_pkg::*; ;
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] paddr, pwdata, prdata;
  logic req_valid, req_last, req_bcast, req_ready, rsp_valid, rsp_last, rsp_exp, rsp_ready;
  logic [7:0] req_byte, req_dst_ep, req_src_ep, rsp_byte, rsp_dst_ep;
  logic [15:0] req_cluster;
  int fails = 0;
  int total_checks = 0;
  fsc_handler fsc_handler_inst (.core_clk_i(core_clk), .resetn_i(resetn), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .req_valid_i(req_valid),
    .req_byte_i(req_byte), .req_last_i(req_last), .req_cluster_i(req_cluster),
    .req_dst_ep_i(req_dst_ep), .req_src_ep_i(req_src_ep), .req_bcast_i(req_bcast),
    .req_ready_o(req_ready), .rsp_valid_o(rsp_valid), .rsp_byte_o(rsp_byte),
    .rsp_last_o(rsp_last), .rsp_dst_ep_o(rsp_dst_ep), .rsp_explicit_o(rsp_exp),
    .rsp_ready_i(rsp_ready), .irq_o(irq));
  fsc_requester fsc_requester_inst (.clk_i(core_clk), .req_valid_o(req_valid),
    .req_byte_o(req_byte), .req_last_o(req_last), .req_cluster_o(req_cluster),
    .req_dst_ep_o(req_dst_ep), .req_src_ep_o(req_src_ep), .req_bcast_o(req_bcast),
    .req_ready_i(req_ready), .rsp_valid_i(rsp_valid), .rsp_byte_i(rsp_byte),
    .rsp_last_i(rsp_last), .rsp_dst_ep_i(rsp_dst_ep), .rsp_explicit_i(rsp_exp),
    .rsp_ready_o(rsp_ready));
  // Core clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Closing report
  task automatic print_verdict;
    fails = fails + fsc_requester_inst.stuck;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    // Hold the access phase until pready is seen at a rising edge
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      print_verdict();
    end
    // Read data and error taken at the completing edge
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge core_clk);
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask : wr
  // Read, mask and compare data and error flag
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic ee);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0000_0000, rd, er);
    `CHK({er, rd & m}, {ee, e})
  endtask : rd_chk
  // Collect a reply and compare its bytes and count
  task automatic rsp_chk(input int lim, input logic slow, input logic [63:0] e, input int n);
    logic [63:0] got;
    int cnt;
    fsc_requester_inst.get_rsp(lim, slow, got, cnt);
    `CHK({got, cnt}, {e, n})
  endtask : rsp_chk
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rd_chk(FSC_ADDR_CTRL, 32'h0000_0007, 32'h0000_0001, 1'b0);
    rd_chk(FSC_ADDR_IRQ_MASK, 32'h0000_0007, 32'h0000_0000, 1'b0);
    rd_chk(32'h0000_0040, 32'h0000_0000, 32'h0000_0000, 1'b1);
    wr(FSC_ADDR_CTRL, 32'h0000_0003);
    wr(FSC_ADDR_IRQ_MASK, 32'h0000_0001);
    $display("test registers done");
    fsc_requester_inst.send_frame(64'h0, FSC_MEM_CLUSTER, FSC_DATA_ENDPOINT, 1'b0);
    rsp_chk(200, 1'b0, {8'h80, 8'h00, FSC_BLOCK_COUNT, FSC_BLOCK_SIZE, 16'h0000}, 8);
    `CHK({fsc_requester_inst.last_ep, fsc_requester_inst.last_fl}, {FSC_DATA_ENDPOINT, 2'b11})
    `CHK(irq, 1'b1)
    wr(FSC_ADDR_IRQ_STAT, 32'h0000_0007);
    `CHK(irq, 1'b0)
    $display("test geometry done");
    fsc_requester_inst.send_frame({16'h0100, 16'h002A, 16'h0000, FSC_BLOCK_SIZE},
      FSC_MEM_CLUSTER, 8'h11, 1'b0);
    rsp_chk(2000, 1'b1, {8'h81, 8'h00, 16'h002A, 16'h0000, 16'h0000}, 8);
    `CHK({fsc_requester_inst.last_ep, fsc_requester_inst.last_fl}, 10'h045)
    wr(FSC_ADDR_PEEK_ADDR, 32'h0000_5400);
    rd_chk(FSC_ADDR_PEEK_DATA, 32'h0000_00FF, 32'h0000_00FF, 1'b0);
    wr(FSC_ADDR_PEEK_ADDR, 32'h0000_55FF);
    rd_chk(FSC_ADDR_PEEK_DATA, 32'h0000_00FF, 32'h0000_00FF, 1'b0);
    $display("test block erase done");
    fsc_requester_inst.send_frame({16'h0100, FSC_BLOCK_COUNT, 16'h0000, FSC_BLOCK_SIZE},
      FSC_MEM_CLUSTER, 8'h11, 1'b0);
    rsp_chk(2000, 1'b0, {8'h81, 8'h01, FSC_BLOCK_COUNT, 32'h0}, 8);
    rd_chk(FSC_ADDR_IRQ_STAT, 32'h0000_0002, 32'h0000_0002, 1'b0);
    wr(FSC_ADDR_IRQ_MASK, 32'h0000_0000);
    `CHK(irq, 1'b0)
    fsc_requester_inst.send_frame(64'h0500_0003_0004_0002, FSC_MEM_CLUSTER, 8'h11, 1'b0, 10);
    rsp_chk(200, 1'b0, 64'h8501_0003_0004_0000, 8);
    $display("test error replies done");
    fsc_requester_inst.send_frame(64'h0, FSC_MEM_CLUSTER, FSC_DATA_ENDPOINT, 1'b1);
    rsp_chk(60, 1'b0, 64'h0, 0);
    rd_chk(FSC_ADDR_CMD_COUNT, 32'h0000_FFFF, 32'h0000_0005, 1'b0);
    fsc_requester_inst.send_frame(64'h0, 16'h0024, FSC_DATA_ENDPOINT, 1'b0);
    rsp_chk(60, 1'b0, 64'h0, 0);
    rd_chk(FSC_ADDR_IRQ_STAT, 32'h0000_0004, 32'h0000_0004, 1'b0);
    $display("test broadcast and drop done");
    wr(FSC_ADDR_CTRL, 32'h0000_0007);
    fsc_requester_inst.send_frame(64'h0100_0005_0000_0000, FSC_MEM_CLUSTER, 8'h11, 1'b0);
    rsp_chk(70000, 1'b0, 64'h8100_0005_0000_0000, 8);
    `CHK({fsc_requester_inst.last_ep, fsc_requester_inst.last_fl}, {8'h11, 2'b11})
    wr(FSC_ADDR_PEEK_ADDR, {16'h0000, FSC_STORE_LAST});
    rd_chk(FSC_ADDR_PEEK_DATA, 32'h0000_00FF, 32'h0000_00FF, 1'b0);
    wr(FSC_ADDR_PEEK_ADDR, 32'h0000_0000);
    rd_chk(FSC_ADDR_PEEK_DATA, 32'h0000_00FF, 32'h0000_00FF, 1'b0);
    $display("test full erase done");
    print_verdict();
  end
endmodule : fsc_handler_bench
